// [rtl/gcs_pkg.sv]
// Constants for the global configuration and status register bank.
// Assumes a 40-bit serial datagram: write flag, 7-bit address, 32-bit data.
package gcs_pkg;

  // ----------------------------------------------------------------
  // Datagram layout
  // ----------------------------------------------------------------
  localparam int DGRAM_W = 40;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 7;
  localparam int WRITE_BIT = 39;
  localparam int ADDR_LSB = 32;
  localparam logic [7:0] WRITE_ADD = 8'h80;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CONFIG = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_STATUS = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_TEST_SELECT = 7'h03;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int GCONF_W = 11;
  localparam int GLOBAL_STATUS_W = 4;
  localparam int TSEL_W = 4;
  localparam int GC_OUT_EN = 3;
  localparam int GC_TEST_MODE = 7;
  localparam int GC_INV_ONE = 8;
  localparam int GC_INV_TWO = 9;
  localparam int GC_LOCK = 10;
  localparam int GS_RESET = 0;
  localparam int GS_DRV_ONE = 1;
  localparam int GS_DRV_TWO = 2;
  localparam int GS_CP_UV = 3;
  localparam int STATUS_FLAGS_W = 3;

  // Writable bits of global_config; reserved bits 0..2 and 4..6 stay zero
  localparam logic [GCONF_W-1:0] GCONF_MASK = 11'h788;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [GCONF_W-1:0] GCONF_RST = 11'h000;
  localparam logic [TSEL_W-1:0] TSEL_RST = 4'h0;
  localparam logic [GLOBAL_STATUS_W-1:0] GLOBAL_STATUS_RST = 4'h1;
  localparam logic [DGRAM_W-1:0] REPLY_RST = 40'h01_0000_0000;
  localparam logic [DGRAM_W-1:0] SHIFT_RST = 40'h00_0000_0000;

endpackage : gcs_pkg

// [rtl/gcs_spi_frame.sv]
// Serial datagram shifter for the register bank, mode 3 framing.
// Assumes SCK at most a quarter of core_clk; pins are asynchronous.
`timescale 1ns/1ns
module gcs_spi_frame
  import gcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sdi,
  input wire logic csn,
  input wire logic [DGRAM_W-1:0] reply_word,
  output logic sdo_o,
  output logic sdo_oe,
  output logic frame_valid,
  output logic [DGRAM_W-1:0] frame_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [2:0] prev;
    logic [DGRAM_W-1:0] shift;
    logic sdo;
    logic valid;
    logic [DGRAM_W-1:0] frame;
  } gcs_spi_state_type;

  gcs_spi_state_type st_r;
  gcs_spi_state_type st_nxt;

  logic sck_s;
  logic sdi_s;
  logic csn_s;

  assign sck_s = st_r.sync[2];
  assign sdi_s = st_r.sync[1];
  assign csn_s = st_r.sync[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = {sck, sdi, csn};
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
    st_nxt.valid = 1'b0;
    if (st_r.prev[0] && !csn_s)
    begin
      // Reply is loaded as the frame opens; first bit out before first edge
      st_nxt.shift = reply_word;
      st_nxt.sdo = reply_word[DGRAM_W-1];
    end
    else if (!csn_s)
    begin
      if (sck_s && !st_r.prev[2])
      begin
        st_nxt.shift = {st_r.shift[DGRAM_W-2:0], sdi_s};
      end
      if (!sck_s && st_r.prev[2])
      begin
        st_nxt.sdo = st_r.shift[DGRAM_W-1];
      end
    end
    else if (!st_r.prev[0])
    begin
      // Only the last 40 bits before CSN rises count, which also chains devices
      st_nxt.valid = 1'b1;
      st_nxt.frame = st_r.shift;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      st_r.meta <= 3'h5;
      st_r.sync <= 3'h5;
      st_r.prev <= 3'h5;
      st_r.shift <= SHIFT_RST;
      st_r.sdo <= 1'b0;
      st_r.valid <= 1'b0;
      st_r.frame <= SHIFT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sdo_o = st_r.sdo;
  assign sdo_oe = !csn_s;
  assign frame_valid = st_r.valid;
  assign frame_data = st_r.frame;

endmodule : gcs_spi_frame

// [rtl/gcs_regs.sv]
// Global configuration and status register bank of a two-axis controller.
// Assumes fault inputs come from analog monitors, asynchronous to core_clk;
// the position pulse and interrupt requests come from logic on core_clk.
// The reply word is picked up by the shifter when the next frame opens.
`timescale 1ns/1ns

// Summary of operation
// - Every register holds zero after reset unless another value is given for it.
// - Address bit 7 set (address plus 0x80) marks a write; without it the access is a read.
// - Read-only ignores writes, write-only takes writes, read-write both, flags clear on read.
// - global_config sits at address 0x00, is 11 bits wide, with bits 0..2 and 4..6 reserved.
// - Config bit 3 low floats the interrupt and position pulse pins; high drives them.
// - Config bit 7 routes the analog test signal picked by the test select to right switch two.
// - Config bit 8 inverts the rotation direction of motor one.
// - Config bit 9 inverts the rotation direction of motor two.
// - Once config bit 10 is set, further global_config writes are ignored until reset.
// - Status bit 0 is set after every reset and clears when global_status is read.
// - Status bit 1 is set on a driver one shutdown and stays set until global_status is read.
// - Status bit 2 flags a driver two shutdown and bit 3 a charge pump undervoltage.
// - A driver fault flag does not clear on read while its fault is still present.
// - The reset and both driver flags are mirrored in the low three bits of the status byte.
module gcs_regs
  import gcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sdi,
  input wire logic csn,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic driver_one_fault,
  input wire logic driver_two_fault,
  input wire logic charge_pump_undervoltage,
  input wire logic int_req,
  input wire logic position_pulse_req,
  output logic int_pin_o,
  output logic int_pin_oe,
  output logic position_pulse_pin_o,
  output logic position_pulse_pin_oe,
  output logic right_switch_two_test_en,
  output logic [TSEL_W-1:0] test_select,
  output logic invert_dir_motor_one,
  output logic invert_dir_motor_two
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] fault_meta;
    logic [2:0] fault_sync;
    logic [GCONF_W-1:0] gconf;
    logic [TSEL_W-1:0] tsel;
    logic [GLOBAL_STATUS_W-1:0] global_status;
    logic [DGRAM_W-1:0] reply;
    logic int_out;
    logic pulse_out;
  } gcs_regs_state_type;

  gcs_regs_state_type st_r;
  gcs_regs_state_type st_nxt;

  logic frame_valid;
  logic [DGRAM_W-1:0] frame_data;

  gcs_spi_frame u_spi (
    .core_clk(core_clk),
    .resetn(resetn),
    .sck(sck),
    .sdi(sdi),
    .csn(csn),
    .reply_word(st_r.reply),
    .sdo_o(sdo_o),
    .sdo_oe(sdo_oe),
    .frame_valid(frame_valid),
    .frame_data(frame_data)
  );

  // ----------------------------------------------------------------
  // Datagram decode
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [DGRAM_W-1:0] dg, input logic [ADDR_W-1:0] a);
    hits = (dg[ADDR_LSB +: ADDR_W] == a);
  endfunction : hits

  // Upper status bits belong to ramp logic outside this bank
  function automatic logic [7:0] status_byte(input logic [STATUS_FLAGS_W-1:0] flags);
    status_byte = 8'(flags);
  endfunction : status_byte

  logic is_write;
  logic rd_global_status;
  logic [DATA_W-1:0] wdata;
  logic [2:0] fault_now;

  assign is_write = frame_data[WRITE_BIT];
  assign wdata = frame_data[DATA_W-1:0];
  assign rd_global_status = frame_valid && !is_write && hits(frame_data, ADDR_GLOBAL_STATUS);
  assign fault_now = st_r.fault_sync;

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  logic gconf_locked;
  logic wr_gconf;
  logic wr_tsel;

  // lock holds until reset
  // The lock bit refuses its own clearing too; only reset frees it
  assign gconf_locked = st_r.gconf[GC_LOCK];
  assign wr_gconf = frame_valid && is_write && hits(frame_data, ADDR_GLOBAL_CONFIG)
    && !gconf_locked;
  assign wr_tsel = frame_valid && is_write && hits(frame_data, ADDR_TEST_SELECT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [DATA_W-1:0] rdata;
    rdata = '0;
    st_nxt = st_r;
    // Fault monitors are analog, so two flops before any use
    st_nxt.fault_meta = {charge_pump_undervoltage, driver_two_fault, driver_one_fault};
    st_nxt.fault_sync = st_r.fault_meta;

    if (rd_global_status)
    begin
      st_nxt.global_status = '0;
    end
    // driver one, driver two and charge pump flags
    // present fault blocks the clear
    // Set comes after the clear, so a fault in the read cycle is never lost
    for (int i = 0; i < 3; i++)
    begin
      if (fault_now[i])
      begin
        st_nxt.global_status[GS_DRV_ONE + i] = 1'b1;
      end
    end

    if (wr_gconf)
    begin
      st_nxt.gconf = wdata[GCONF_W-1:0] & GCONF_MASK;
    end
    if (wr_tsel)
    begin
      st_nxt.tsel = wdata[TSEL_W-1:0];
    end

    // reserved and write-only read as zero
    if (hits(frame_data, ADDR_GLOBAL_CONFIG))
    begin
      rdata[GCONF_W-1:0] = st_r.gconf;
    end
    else if (hits(frame_data, ADDR_GLOBAL_STATUS))
    begin
      rdata[GLOBAL_STATUS_W-1:0] = st_r.global_status;
    end

    // status byte latched at end of access
    // Flags after this frame's clear, so a reply never shows a flag already read
    if (frame_valid)
    begin
      st_nxt.reply = '0;
      st_nxt.reply[DGRAM_W-1:ADDR_LSB] = status_byte(st_nxt.global_status[STATUS_FLAGS_W-1:0]);
      if (!is_write)
      begin
        st_nxt.reply[DATA_W-1:0] = rdata;
      end
    end

    st_nxt.int_out = int_req;
    st_nxt.pulse_out = position_pulse_req;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // zero after reset, except the reset status flag and the reply
      // Synchronisers start at the idle level: no false fault after reset
      st_r.fault_meta <= 3'h0;
      st_r.fault_sync <= 3'h0;
      st_r.gconf <= GCONF_RST;
      st_r.tsel <= TSEL_RST;
      st_r.global_status <= GLOBAL_STATUS_RST;
      st_r.reply <= REPLY_RST;
      st_r.int_out <= 1'b0;
      st_r.pulse_out <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Floating pins need board pull-ups while the enable is low
  // pins float unless enabled
  assign int_pin_o = st_r.int_out;
  assign int_pin_oe = st_r.gconf[GC_OUT_EN];
  assign position_pulse_pin_o = st_r.pulse_out;
  assign position_pulse_pin_oe = st_r.gconf[GC_OUT_EN];
  // analog test route to right switch two
  assign right_switch_two_test_en = st_r.gconf[GC_TEST_MODE];
  assign test_select = st_r.tsel;
  assign invert_dir_motor_one = st_r.gconf[GC_INV_ONE];
  assign invert_dir_motor_two = st_r.gconf[GC_INV_TWO];

endmodule : gcs_regs

// [dv/gcs_host.sv]
// SPI host model for the register bank, mode 3, 40-bit frames.
// Assumes core_clk of 50 ns; link clock period 8 core_clk.
`timescale 1ns/1ns
module gcs_host (
  input wire logic core_clk,
  input wire logic sdo_o,
  output logic sck,
  output logic sdi,
  output logic csn
);
  initial
  begin
    sck = 1'b1;
    sdi = 1'b0;
    csn = 1'b1;
  end
  // write flag comes in bit 39
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    csn <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 39; i >= 0; i--)
    begin
      sck <= 1'b0;
      sdi <= tx[i];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      rx[i] = sdo_o;
      repeat (4) @(posedge core_clk);
    end
    csn <= 1'b1;
    // Released line must not keep its last bit
    sdi <= ~sdi;
    repeat (12) @(posedge core_clk);
  endtask : xfer
endmodule : gcs_host

// [dv/gcs_regs_chk.sv]
// Port checker for the register bank.
// Assumes one clock domain, synchronous active low reset.
`timescale 1ns/1ns
module gcs_regs_chk
  import gcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic csn,
  input wire logic sdo_oe,
  input wire logic int_req,
  input wire logic position_pulse_req,
  input wire logic int_pin_o,
  input wire logic int_pin_oe,
  input wire logic position_pulse_pin_o,
  input wire logic position_pulse_pin_oe,
  input wire logic right_switch_two_test_en,
  input wire logic [TSEL_W-1:0] test_select,
  input wire logic invert_dir_motor_one,
  input wire logic invert_dir_motor_two
);
  logic [4:0] cfg;
  assign cfg = {invert_dir_motor_two, invert_dir_motor_one, right_switch_two_test_en,
    int_pin_oe, position_pulse_pin_oe};
  default clocking cb @(posedge core_clk);
  endclocking
  sequence s_frame_end;
    $rose(csn) ##1 csn[*2];
  endsequence
  property p_rst_zero;
    !resetn |=> cfg == 5'h00 && test_select == 4'h0 && !sdo_oe;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset value");
  property p_int_dly;
    disable iff (!resetn) $past(resetn) |-> int_pin_o == $past(int_req);
  endproperty
  a_int_dly: assert property (p_int_dly) else $error("int pin");
  property p_pp_dly;
    disable iff (!resetn) $past(resetn) |-> position_pulse_pin_o == $past(position_pulse_req);
  endproperty
  a_pp_dly: assert property (p_pp_dly) else $error("pulse pin");
  property p_oe_pair;
    disable iff (!resetn) int_pin_oe == position_pulse_pin_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enable pair");
  property p_cfg_frame;
    disable iff (!resetn) $past(resetn) && $changed(cfg) |-> $past(csn, 3);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("config change");
  property p_tsel_frame;
    disable iff (!resetn) $past(resetn) && $changed(test_select) |-> $past(csn, 3);
  endproperty
  a_tsel_frame: assert property (p_tsel_frame) else $error("select change");
  property p_oe_on;
    disable iff (!resetn) $fell(csn) |-> ##[1:4] sdo_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo enable");
  property p_oe_off;
    disable iff (!resetn) s_frame_end |-> ##[0:3] !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo release");
endmodule : gcs_regs_chk
bind gcs_regs gcs_regs_chk chk_u (.core_clk, .resetn, .csn, .sdo_oe, .int_req,
  .position_pulse_req, .int_pin_o, .int_pin_oe, .position_pulse_pin_o, .position_pulse_pin_oe,
  .right_switch_two_test_en, .test_select, .invert_dir_motor_one, .invert_dir_motor_two);

// [dv/tb.sv]
// Self-checking bench for the register bank.
// Assumes gcs_pkg, host model and checker compiled first.
`timescale 1ns/1ns
module tb;
  import gcs_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ireq = 1'b0;
  logic preq = 1'b0;
  logic [2:0] flt = 3'h0;
  logic sck, sdi, csn, sdo_o, sdo_oe, io, ie, po, pe, rs2, inv1, inv2;
  logic [TSEL_W-1:0] tsel;
  logic [DGRAM_W-1:0] rx;
  // Written value beside its read back
  logic [21:0] rows [4] = '{{11'h008, 11'h008}, {11'h080, 11'h080}, {11'h300, 11'h300},
    {11'h3ff, 11'h388}};
  int miscompares = 0;
  int comparisons = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) ireq <= ~ireq;
  always @(posedge core_clk) preq <= ireq;
  gcs_host host_u (.core_clk, .sdo_o, .sck, .sdi, .csn);
  gcs_regs dut_u (.core_clk, .resetn, .sck, .sdi, .csn, .sdo_o, .sdo_oe,
    .driver_one_fault(flt[0]), .driver_two_fault(flt[1]), .charge_pump_undervoltage(flt[2]),
    .int_req(ireq), .position_pulse_req(preq), .int_pin_o(io), .int_pin_oe(ie),
    .position_pulse_pin_o(po), .position_pulse_pin_oe(pe), .right_switch_two_test_en(rs2),
    .test_select(tsel), .invert_dir_motor_one(inv1), .invert_dir_motor_two(inv2));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer({a, d}, rx);
  endtask : acc
  // Reply of a read arrives one frame later
  task automatic rd2(input logic [7:0] a);
    acc(a, 32'h0);
    acc(a, 32'h0);
  endtask : rd2
  task automatic tally_and_finish;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    acc(8'h01, 32'h0);
    chk(rx, REPLY_RST);
    acc(8'h00, 32'h0);
    chk(rx, 40'h00_0000_0001);
    foreach (rows[i])
    begin
      acc(8'h80, 32'(rows[i][21:11]));
      chk(40'({inv2, inv1, rs2, pe, ie}), 40'({rows[i][9:7], rows[i][3], rows[i][3]}));
      rd2(8'h00);
      chk(rx, 40'(rows[i][10:0]));
    end
    acc(8'h83, 32'h5);
    chk(40'(tsel), 40'h5);
    acc(8'h81, 32'hf);
    acc(8'h03, 32'h0);
    acc(8'h01, 32'h0);
    chk(rx, 40'h0);
    acc(8'h00, 32'h0);
    chk(rx, 40'h0);
    for (int i = 0; i < 3; i++)
    begin
      flt <= 3'(1 << i);
      repeat (4) @(posedge core_clk);
      flt <= 3'h0;
      rd2(8'h01);
      chk(rx, 40'(2 << i));
      flt <= 3'(1 << i);
      rd2(8'h01);
      chk(rx, {(i < 2) ? 8'(2 << i) : 8'h0, 32'(2 << i)});
      flt <= 3'h0;
      acc(8'h01, 32'h0);
      chk(rx, {(i < 2) ? 8'(2 << i) : 8'h0, 32'(2 << i)});
    end
    acc(8'h80, 32'h500);
    acc(8'h80, 32'h0);
    chk(40'({inv1, inv2}), 40'h2);
    resetn <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk(40'({inv1, ie, rs2, tsel}), 40'h0);
    @(posedge core_clk);
    acc(8'h01, 32'h0);
    chk(rx, REPLY_RST);
    acc(8'h80, 32'h200);
    chk(40'(inv2), 40'h1);
    tally_and_finish();
  end
  // Run needs about 0.64 ms
  initial
  begin
    #3000000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
